/* File: logic/twdac_pkg.sv */
`default_nettype none
package twdac_pkg;
   // Spike filter on both bus lines: pulses under this width are dropped.
   localparam int unsigned FILT_NS = 50;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned FILT_CYC_I = (FILT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [2:0] FILT_LAST = 3'(FILT_CYC_I - 1);
   // Fastest serial clock the engine is sized for, in kHz.
   localparam int unsigned SCL_MAX_KHZ = 400;
   // Idle level of both bus lines and the power-on latch code.
   localparam logic LINE_IDLE = 1'b1;
   localparam logic [7:0] CODE_RST = 8'h00;
   // Slave address layout.
   localparam logic [2:0] ADDR_FIXED = 3'h2;
   localparam logic [1:0] ADDR_TWO_PIN_HI = 2'h3;
   localparam int unsigned ADDR_RW_BIT = 0;
   // Command byte field positions, MSB first on the wire.
   localparam int unsigned CMD_CLR_BIT = 4;
   localparam int unsigned CMD_PD_BIT = 3;
   localparam int unsigned CMD_SEL_BIT = 0;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_ACK, ST_SKIP} twdac_state_t;

   // Rising and falling edge of a registered level.
   function automatic logic twdac_rise(input logic prev, input logic cur);
      return cur & ~prev;
   endfunction : twdac_rise

   function automatic logic twdac_fall(input logic prev, input logic cur);
      return prev & ~cur;
   endfunction : twdac_fall

   // Compares a received 7-bit address with the pin-programmed one.
   function automatic logic twdac_addr_match(input logic [6:0] a, input logic [3:0] pins,
                                             input logic four);
      logic [6:0] want;
      want = four ? {ADDR_FIXED, pins} : {ADDR_FIXED, ADDR_TWO_PIN_HI, pins[1:0]};
      return a == want;
   endfunction : twdac_addr_match
endpackage : twdac_pkg
`default_nettype wire

/* File: logic/twdac_line_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface twdac_line_if;
   logic scl_lvl;
   logic sda_lvl;
   logic link_bit;
   modport filt (output scl_lvl, output sda_lvl);
   modport samp (output link_bit);
   modport eng (input scl_lvl, input sda_lvl, input link_bit);
endinterface : twdac_line_if
`default_nettype wire

/* File: logic/twdac_filter.sv */
`timescale 1ns/100ps
`default_nettype none
module twdac_filter (
   input wire logic clk, // System clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic scl_pin, // Raw serial clock pin.
   input wire logic sda_pin, // Raw serial data pin.
   twdac_line_if.filt line // Filtered line levels.
);
   import twdac_pkg::*;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] lvl;
      logic [1:0][2:0] cnt;
   } twdac_filt_t;

   twdac_filt_t state_r;
   twdac_filt_t state_nxt;

   // Each line moves only after its synchronised level differs for the full filter span.
   always_comb begin
      state_nxt = state_r;
      state_nxt.s1 = {scl_pin, sda_pin};
      state_nxt.s2 = state_r.s1;
      for (int i = 0; i < 2; i++) begin
         if (state_r.s2[i] != state_r.lvl[i]) begin
            if (state_r.cnt[i] == FILT_LAST) begin
               state_nxt.lvl[i] = state_r.s2[i];
               state_nxt.cnt[i] = 3'h0;
            end else begin
               state_nxt.cnt[i] = state_r.cnt[i] + 3'h1;
            end
         end else begin
            state_nxt.cnt[i] = 3'h0;
         end
      end
   end

   // State register, lines idle high after reset.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= '0;
         state_r.s1 <= {LINE_IDLE, LINE_IDLE};
         state_r.s2 <= {LINE_IDLE, LINE_IDLE};
         state_r.lvl <= {LINE_IDLE, LINE_IDLE};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign line.scl_lvl = state_r.lvl[1];
   assign line.sda_lvl = state_r.lvl[0];

   AST_FILT_SPAN: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r.lvl != $past(state_r.lvl)) |-> $past(state_r.cnt[0] == FILT_LAST
         || state_r.cnt[1] == FILT_LAST))
      else $error("Filtered line moved before the spike span elapsed.");
endmodule : twdac_filter
`default_nettype wire

/* File: logic/twdac_sampler.sv */
`timescale 1ns/100ps
`default_nettype none
module twdac_sampler (
   input wire logic scl_link_clk, // Serial clock pin used as the link clock.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic sda_pin, // Raw serial data pin.
   twdac_line_if.samp line // Captured data bit.
);
   import twdac_pkg::*;

   typedef struct packed {
      logic bit_v;
   } twdac_samp_t;

   twdac_samp_t state_r;
   twdac_samp_t state_nxt;

   // The data line is taken on each rising serial clock, where it is held stable.
   always_comb begin
      state_nxt = state_r;
      state_nxt.bit_v = sda_pin;
   end

   // Link-side register, idle high after reset.
   always_ff @(posedge scl_link_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r.bit_v <= LINE_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign line.link_bit = state_r.bit_v;
endmodule : twdac_sampler
`default_nettype wire

/* File: logic/twdac_top.sv */
`timescale 1ns/100ps
`default_nettype none
module twdac_top (
   input wire logic clk, // System clock, 100 MHz.
   input wire logic arst_n, // Asynchronous reset, active low.
   input wire logic scl_link_clk, // Serial clock pin, also the link clock.
   input wire logic sda_in, // Serial data pin level.
   output logic sda_o, // Serial data drive value, always low.
   output logic sda_oe, // Serial data pull-down enable, high while driving.
   input wire logic slave_addr_pin_zero, // Address pin 0.
   input wire logic slave_addr_pin_one, // Address pin 1.
   input wire logic slave_addr_pin_two, // Address pin 2, four-pin variant only.
   input wire logic slave_addr_pin_three, // Address pin 3, four-pin variant only.
   input wire logic four_pin_variant, // High selects the sixteen-address variant.
   output logic [7:0] dac0_code, // Output latch of channel 0.
   output logic [7:0] dac1_code, // Output latch of channel 1.
   output logic dac_float // High while powered down, outputs floating.
);
   import twdac_pkg::*;

   typedef struct packed {
      twdac_state_t st;
      twdac_state_t ack_next;
      logic scl_p;
      logic sda_p;
      logic bit_s1;
      logic bit_s2;
      logic [3:0] pin_s1;
      logic [3:0] pin_s2;
      logic four_s1;
      logic four_s2;
      logic [2:0] bit_cnt;
      logic [7:0] shreg;
      logic addressed;
      logic have_cmd;
      logic pend_pd;
      logic skip_out;
      logic sel;
      logic [7:0] in0;
      logic [7:0] in1;
      logic [7:0] out0;
      logic [7:0] out1;
      logic pwr_down;
      logic ack_oe;
   } twdac_eng_t;

   twdac_eng_t state_r;
   twdac_eng_t state_nxt;
   twdac_line_if line ();

   logic start_w;
   logic stop_w;
   logic scl_rise_w;
   logic scl_fall_w;
   logic byte_done_w;
   logic [7:0] byte_w;

   // Spike filter and synchroniser for both bus lines.
   twdac_filter u_filter (
      .clk (clk),
      .arst_n (arst_n),
      .scl_pin (scl_link_clk),
      .sda_pin (sda_in),
      .line (line.filt)
   );

   // Link-domain capture of the data bit on the serial clock.
   twdac_sampler u_sampler (
      .scl_link_clk (scl_link_clk),
      .arst_n (arst_n),
      .sda_pin (sda_in),
      .line (line.samp)
   );

   // Bus conditions seen on the filtered lines.
   assign scl_rise_w = twdac_rise(state_r.scl_p, line.scl_lvl);
   assign scl_fall_w = twdac_fall(state_r.scl_p, line.scl_lvl);
   assign start_w = line.scl_lvl & state_r.scl_p & twdac_fall(state_r.sda_p, line.sda_lvl);
   assign stop_w = line.scl_lvl & state_r.scl_p & twdac_rise(state_r.sda_p, line.sda_lvl);
   // A byte is whole on the eighth rising clock; bits shift in MSB first.
   assign byte_w = {state_r.shreg[6:0], state_r.bit_s2};
   assign byte_done_w = scl_rise_w && (state_r.bit_cnt == BIT_LAST)
      && (state_r.st == ST_ADDR || state_r.st == ST_CMD || state_r.st == ST_DATA);

   // Protocol engine: framing, address match, acknowledge and latch updates.
   always_comb begin
      state_nxt = state_r;
      state_nxt.scl_p = line.scl_lvl;
      state_nxt.sda_p = line.sda_lvl;
      // The link-side bit is a level stable for the whole clock high phase.
      state_nxt.bit_s1 = line.link_bit;
      state_nxt.bit_s2 = state_r.bit_s1;
      state_nxt.pin_s1 = {slave_addr_pin_three, slave_addr_pin_two,
                          slave_addr_pin_one, slave_addr_pin_zero};
      state_nxt.pin_s2 = state_r.pin_s1;
      state_nxt.four_s1 = four_pin_variant;
      state_nxt.four_s2 = state_r.four_s1;
      if (stop_w) begin
         // Only an addressed device that saw a whole command byte acts on STOP.
         if (state_r.addressed && state_r.have_cmd) begin
            state_nxt.out0 = state_r.in0;
            state_nxt.out1 = state_r.in1;
            state_nxt.pwr_down = state_r.pend_pd;
         end
         // A partial byte is simply dropped when the frame ends.
         state_nxt.st = ST_IDLE;
         state_nxt.addressed = 1'b0;
         state_nxt.have_cmd = 1'b0;
         state_nxt.skip_out = 1'b0;
         state_nxt.ack_oe = 1'b0;
      end else if (start_w) begin
         // A START, repeated or not, restarts address matching; input latches stay.
         state_nxt.st = ST_ADDR;
         state_nxt.bit_cnt = 3'h0;
         state_nxt.addressed = 1'b0;
         state_nxt.have_cmd = 1'b0;
         state_nxt.skip_out = 1'b0;
         state_nxt.ack_oe = 1'b0;
      end else begin
         unique case (state_r.st)
            ST_IDLE, ST_SKIP: begin
               // Wait for the next START; nothing here touches any latch.
               state_nxt.ack_oe = 1'b0;
            end
            ST_ADDR, ST_CMD, ST_DATA: begin
               if (scl_rise_w) begin
                  state_nxt.shreg = byte_w;
                  state_nxt.bit_cnt = state_r.bit_cnt + 3'h1;
               end
               if (byte_done_w) begin
                  state_nxt.st = ST_ACK;
                  unique case (state_r.st)
                     ST_ADDR: begin
                        // Write address only; a read request is not answered.
                        if (twdac_addr_match(byte_w[7:1], state_r.pin_s2, state_r.four_s2)
                            && !byte_w[ADDR_RW_BIT]) begin
                           state_nxt.addressed = 1'b1;
                           state_nxt.ack_next = ST_CMD;
                        end else begin
                           state_nxt.st = ST_SKIP;
                        end
                     end
                     ST_CMD: begin
                        // Reserved and don't-care bits are ignored.
                        state_nxt.have_cmd = 1'b1;
                        state_nxt.pend_pd = byte_w[CMD_PD_BIT];
                        state_nxt.sel = byte_w[CMD_SEL_BIT];
                        state_nxt.skip_out = byte_w[CMD_CLR_BIT];
                        if (byte_w[CMD_CLR_BIT]) begin
                           state_nxt.in0 = CODE_RST;
                           state_nxt.in1 = CODE_RST;
                        end
                        state_nxt.ack_next = ST_DATA;
                     end
                     default: begin
                        // Output byte: load the selected latch unless a clear skips it.
                        if (!state_r.skip_out) begin
                           if (state_r.sel) begin
                              state_nxt.in1 = byte_w;
                           end else begin
                              state_nxt.in0 = byte_w;
                           end
                        end
                        state_nxt.skip_out = 1'b0;
                        state_nxt.ack_next = ST_CMD;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               // Pull data low from the eighth falling clock to the ninth one.
               if (scl_fall_w) begin
                  if (!state_r.ack_oe) begin
                     state_nxt.ack_oe = 1'b1;
                  end else begin
                     state_nxt.ack_oe = 1'b0;
                     state_nxt.st = state_r.ack_next;
                     state_nxt.bit_cnt = 3'h0;
                  end
               end
            end
            default: begin
               state_nxt.st = ST_IDLE;
            end
         endcase
      end
   end

   // Engine register; power-on state has all latches clear and outputs live.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= '0;
         state_r.st <= ST_IDLE;
         state_r.ack_next <= ST_CMD;
         state_r.scl_p <= LINE_IDLE;
         state_r.sda_p <= LINE_IDLE;
         state_r.bit_s1 <= LINE_IDLE;
         state_r.bit_s2 <= LINE_IDLE;
         state_r.in0 <= CODE_RST;
         state_r.in1 <= CODE_RST;
         state_r.out0 <= CODE_RST;
         state_r.out1 <= CODE_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Open-drain data pin with its drive tied low; the enable and latch outputs come from registers.
   assign sda_o = 1'b0;
   assign sda_oe = state_r.ack_oe;
   assign dac0_code = state_r.out0;
   assign dac1_code = state_r.out1;
   assign dac_float = state_r.pwr_down;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_byte_in(twdac_state_t s);
      byte_done_w && state_r.st == s && !start_w && !stop_w;
   endsequence

   sequence s_ack_second_fall;
      state_r.st == ST_ACK && state_r.ack_oe && scl_fall_w && !start_w && !stop_w;
   endsequence

   sequence s_addressed_stop;
      stop_w && state_r.addressed && state_r.have_cmd;
   endsequence

   AST_OUT_AT_STOP: assert property (
      (state_r.out0 != $past(state_r.out0) || state_r.out1 != $past(state_r.out1))
      |-> $past(stop_w && state_r.addressed && state_r.have_cmd))
      else $error("Output latch changed without an addressed STOP.");

   AST_STOP_TRANSFER: assert property (
      s_addressed_stop |=> state_r.out0 == $past(state_r.in0)
         && state_r.out1 == $past(state_r.in1) && state_r.st == ST_IDLE)
      else $error("Addressed STOP did not copy the input latches.");

   AST_PD_AT_STOP: assert property (
      s_addressed_stop |=> dac_float == $past(state_r.pend_pd))
      else $error("Power state did not follow the last command at STOP.");

   AST_PD_ONLY_STOP: assert property (
      $changed(dac_float) |-> $past(stop_w && state_r.addressed))
      else $error("Power state changed away from an addressed STOP.");

   AST_UNADDR_STOP: assert property (
      stop_w && !state_r.addressed |=> $stable(state_r.out0) && $stable(state_r.out1)
         && $stable(dac_float))
      else $error("Unaddressed STOP disturbed latches or power state.");

   AST_ADDR_MATCH: assert property (
      s_byte_in(ST_ADDR) ##0 (twdac_addr_match(byte_w[7:1], state_r.pin_s2,
         state_r.four_s2) && !byte_w[ADDR_RW_BIT]) |=> state_r.addressed
         && state_r.st == ST_ACK)
      else $error("Matching write address was not accepted.");

   AST_ADDR_MISS: assert property (
      s_byte_in(ST_ADDR) ##0 !twdac_addr_match(byte_w[7:1], state_r.pin_s2,
         state_r.four_s2) |=> state_r.st == ST_SKIP && !sda_oe)
      else $error("Foreign address was acknowledged.");

   AST_PD_LAST_CMD: assert property (
      s_byte_in(ST_CMD) |=> state_r.pend_pd == $past(byte_w[CMD_PD_BIT])
         && state_r.have_cmd)
      else $error("Command byte did not overwrite pending power-down.");

   AST_CLEAR: assert property (
      s_byte_in(ST_CMD) ##0 byte_w[CMD_CLR_BIT] |=> state_r.in0 == CODE_RST
         && state_r.in1 == CODE_RST && state_r.skip_out)
      else $error("Clear command did not zero input latches.");

   AST_SKIP_OUT: assert property (
      s_byte_in(ST_DATA) ##0 state_r.skip_out |=> $stable(state_r.in0)
         && $stable(state_r.in1) && !state_r.skip_out)
      else $error("Output byte after a clear was not discarded.");

   AST_LOAD_SEL: assert property (
      s_byte_in(ST_DATA) ##0 (!state_r.skip_out && !state_r.sel)
      |=> state_r.in0 == $past(byte_w) && $stable(state_r.in1))
      else $error("Output byte did not reach the selected latch.");

   AST_LOAD_SEL_ONE: assert property (
      s_byte_in(ST_DATA) ##0 (!state_r.skip_out && state_r.sel)
      |=> state_r.in1 == $past(byte_w) && $stable(state_r.in0))
      else $error("Output byte did not reach the second channel latch.");

   AST_LATE_STOP: assert property (
      stop_w && state_r.st == ST_DATA |=> $stable(state_r.in0) && $stable(state_r.in1)
         && $stable(state_r.pend_pd))
      else $error("Partial output byte took effect.");

   AST_ACK_DRIVE: assert property (
      state_r.st == ST_ACK && !state_r.ack_oe && scl_fall_w && !start_w && !stop_w
      |=> sda_oe)
      else $error("Acknowledge not driven after the eighth falling clock.");

   AST_ACK_RELEASE: assert property (
      s_ack_second_fall |=> !sda_oe && state_r.bit_cnt == 3'h0 ##1 !sda_oe)
      else $error("Acknowledge not released at the ninth falling clock.");

   AST_ACK_SCOPE: assert property (
      sda_oe |-> state_r.st == ST_ACK && state_r.addressed)
      else $error("Data line driven outside an acknowledge.");

   AST_REPEAT_START: assert property (
      start_w |=> $stable(state_r.in0) && $stable(state_r.in1)
         && !state_r.addressed && state_r.st == ST_ADDR)
      else $error("START altered pending data or kept addressing.");

   AST_EARLY_STOP: assert property (
      stop_w && state_r.st == ST_CMD |=> $stable(state_r.pend_pd)
         && $stable(state_r.in0) && $stable(state_r.in1))
      else $error("Partial command byte took effect.");
endmodule : twdac_top
`default_nettype wire

/* File: verif/twdac_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Bus master that issues write transmissions, paced by the bench clock.
module twdac_master_model (
   input wire logic clk, // Bench clock that paces every bus phase.
   input wire logic dev_pull, // Device pull-down enable, seen as the acknowledge.
   output logic scl, // Serial clock, still between frames.
   output logic sda_drv // Data drive, low pulls the line down, high releases it.
);
   // Both lines rest high while the bus is idle.
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Waits a number of bench cycles, moving lines only at falling edges.
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   // Data falls while the clock is high; also serves as repeated START.
   task automatic start_cond();
      wt(30);
      sda_drv = 1'b1;
      wt(100);
      scl = 1'b1;
      wt(60);
      sda_drv = 1'b0;
      wt(60);
      scl = 1'b0;
   endtask : start_cond
   // Data rises while the clock is high, then the bus rests free.
   task automatic stop_cond();
      wt(30);
      sda_drv = 1'b0;
      wt(100);
      scl = 1'b1;
      wt(60);
      sda_drv = 1'b1;
      wt(130);
   endtask : stop_cond
   // Sends n bits MSB first; a whole byte gets a ninth clock with data held low.
   // Data moves only while the clock is low, after a hold time.
   task automatic send_bits(input logic [7:0] b, input int n, input logic spike,
                            output logic ack);
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         wt(30);
         sda_drv = b[i];
         if (spike) begin
            // A 30 ns clock pulse in the low phase must be dropped as noise.
            scl = 1'b1;
            #30;
            scl = 1'b0;
         end
         wt(100);
         scl = 1'b1;
         wt(60);
         scl = 1'b0;
      end
      if (n == 8) begin
         wt(30);
         sda_drv = 1'b0;
         wt(100);
         scl = 1'b1;
         wt(30);
         ack = dev_pull;
         wt(30);
         scl = 1'b0;
      end
   endtask : send_bits
endmodule : twdac_master_model
`default_nettype wire

/* File: verif/tb_twdac_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_twdac_top;
   import twdac_pkg::*;
   logic clk, arst_n, scl, sda_drv, sda_o, sda_oe, four, ack, dac_float;
   logic [3:0] pins;
   logic [7:0] dac0_code, dac1_code;
   wire logic sda_in;
   int fails, samples_checked;
   // Open-drain data line: low when either party pulls it down.
   assign sda_in = sda_drv & ~(sda_oe & ~sda_o);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   twdac_top dut_u (.clk(clk), .arst_n(arst_n), .scl_link_clk(scl), .sda_in(sda_in),
      .sda_o(sda_o), .sda_oe(sda_oe), .slave_addr_pin_zero(pins[0]),
      .slave_addr_pin_one(pins[1]), .slave_addr_pin_two(pins[2]),
      .slave_addr_pin_three(pins[3]), .four_pin_variant(four), .dac0_code(dac0_code),
      .dac1_code(dac1_code), .dac_float(dac_float));
   twdac_master_model master_u (.clk(clk), .dev_pull(sda_oe), .scl(scl), .sda_drv(sda_drv));
   // Compares one value and counts the comparison.
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk
   // Sends a whole byte and checks whether it was acknowledged.
   task automatic snd(input logic [7:0] b, input logic e);
      master_u.send_bits(b, 8, 1'b0, ack);
      chk("ack", {7'h0, e}, {7'h0, ack});
   endtask : snd
   // Checks both output latches and the power state after a STOP.
   task automatic outs(input logic [7:0] c0, input logic [7:0] c1, input logic f);
      chk("dac0_code", c0, dac0_code);
      chk("dac1_code", c1, dac1_code);
      chk("dac_float", {7'h0, f}, {7'h0, dac_float});
   endtask : outs
   // Two pairs reach the outputs together, and only at STOP.
   task automatic t_pairs();
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h80, 1'b1);
      snd(8'h01, 1'b1);
      snd(8'h3c, 1'b1);
      chk("dac0_code", 8'h00, dac0_code);
      master_u.stop_cond();
      outs(8'h80, 8'h3c, 1'b0);
   endtask : t_pairs
   // Power-down by a lone command, with paired data, and last command wins.
   task automatic t_power();
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h08, 1'b1);
      master_u.stop_cond();
      outs(8'h80, 8'h3c, 1'b1);
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h08, 1'b1);
      snd(8'h44, 1'b1);
      master_u.stop_cond();
      outs(8'h44, 8'h3c, 1'b1);
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h09, 1'b1);
      snd(8'h11, 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h22, 1'b1);
      master_u.stop_cond();
      outs(8'h22, 8'h11, 1'b0);
   endtask : t_power
   // Clear drops the next output byte; a later pair loads normally.
   task automatic t_clear();
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h10, 1'b1);
      snd(8'hff, 1'b1);
      snd(8'h01, 1'b1);
      snd(8'h55, 1'b1);
      master_u.stop_cond();
      outs(8'h00, 8'h55, 1'b0);
   endtask : t_clear
   // A foreign address or a read is refused and changes nothing.
   task automatic t_foreign();
      master_u.start_cond();
      snd(8'h5e, 1'b0);
      snd(8'h08, 1'b0);
      snd(8'h99, 1'b0);
      master_u.stop_cond();
      master_u.start_cond();
      snd(8'h5d, 1'b0);
      master_u.stop_cond();
      outs(8'h00, 8'h55, 1'b0);
   endtask : t_foreign
   // Repeated START leaves pending data; a later command and STOP move it.
   task automatic t_rep();
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h77, 1'b1);
      master_u.start_cond();
      snd(8'h58, 1'b0);
      master_u.stop_cond();
      outs(8'h00, 8'h55, 1'b0);
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h01, 1'b1);
      master_u.stop_cond();
      outs(8'h77, 8'h55, 1'b0);
   endtask : t_rep
   // STOP inside a command byte, then inside an output byte.
   task automatic t_early();
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h01, 1'b1);
      snd(8'h66, 1'b1);
      master_u.send_bits(8'h18, 5, 1'b0, ack);
      master_u.stop_cond();
      outs(8'h77, 8'h66, 1'b0);
      master_u.start_cond();
      snd(8'h5c, 1'b1);
      snd(8'h08, 1'b1);
      master_u.send_bits(8'hee, 3, 1'b0, ack);
      master_u.stop_cond();
      outs(8'h77, 8'h66, 1'b1);
   endtask : t_early
   // Four-pin addressing, and a short clock spike that must be ignored.
   task automatic t_four();
      four = 1'b1;
      pins = 4'h6;
      master_u.wt(10);
      master_u.start_cond();
      snd(8'h5c, 1'b0);
      master_u.start_cond();
      snd(8'h4c, 1'b1);
      snd(8'h00, 1'b1);
      master_u.send_bits(8'h5a, 8, 1'b1, ack);
      chk("ack", 8'h01, {7'h0, ack});
      master_u.stop_cond();
      outs(8'h5a, 8'h66, 1'b0);
   endtask : t_four
   // Reset in mid-run clears every latch; a transfer afterwards still works.
   task automatic t_reset();
      arst_n = 1'b0;
      master_u.wt(3);
      outs(8'h00, 8'h00, 1'b0);
      arst_n = 1'b1;
      master_u.wt(10);
      master_u.start_cond();
      snd(8'h4c, 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h12, 1'b1);
      master_u.stop_cond();
      outs(8'h12, 8'h00, 1'b0);
   endtask : t_reset
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   // Cuts a hang short; the scenarios need about 81300 cycles in all.
   initial begin
      repeat (95000) @(posedge clk);
      fails++;
      print_verdict();
   end
   // Reset, then the scenarios in order.
   initial begin
      fails = 0;
      samples_checked = 0;
      arst_n = 1'b0;
      four = 1'b0;
      pins = 4'h2;
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      outs(8'h00, 8'h00, 1'b0);
      master_u.wt(10);
      t_pairs();
      t_power();
      t_clear();
      t_foreign();
      t_rep();
      t_early();
      t_four();
      t_reset();
      print_verdict();
   end
endmodule : tb_twdac_top
`default_nettype wire
